//--- rtl/dsc_core.sv
// Purpose: dual element SIMD core: issue, memory buses, exchange, universal regs, timer, cache
// Assumes: memories answer in the same cycle; instructions arrive with fetch address
// Notes: the mode word is a plain input, sampled each cycle and applied next instruction
`timescale 1ns/1ps
`default_nettype none
module dsc_core (
   input wire logic mclk,                                          // Core clock, 40 MHz
   input wire logic reset_n,                                       // Async reset, active low
   input wire logic [dsc_pkg::DSC_MODE_W-1:0] core_mode_word,      // Mode bits
   input wire dsc_pkg::dsc_insn_t insn_in,                         // Decoded compute instruction
   input wire logic [dsc_pkg::DSC_PC_W-1:0] fetch_addr,            // Address of the instruction
   input wire logic [dsc_pkg::DSC_INSN_W-1:0] fetch_word,          // Word from program bus
   input wire logic fetch_word_valid,                              // Program bus returned insn
   input wire logic pm_data_req,                                   // Program bus data access now
   output logic insn_from_cache,                                   // Instruction came from cache
   output logic [dsc_pkg::DSC_INSN_W-1:0] insn_word,               // Issued instruction word
   output logic stall,                                             // Fetch lost to bus conflict
   input wire logic [dsc_pkg::DSC_BUS_W-1:0] data_memory_bus,      // Data bus read word
   input wire logic [dsc_pkg::DSC_BUS_W-1:0] program_memory_bus,   // Program bus read word
   input wire logic [dsc_pkg::DSC_AW-1:0] store_reg,               // Register to store
   output logic [dsc_pkg::DSC_BUS_W-1:0] store_word,               // Paired store word
   output logic [dsc_pkg::DSC_WORD_W-1:0] mr_x,                    // Primary element mult result
   output logic [dsc_pkg::DSC_WORD_W-1:0] mr_y,                    // Second element mult result
   input wire dsc_pkg::dsc_pxop_t px_op,                           // Exchange register load
   input wire logic px_to_rf,                                      // Move exchange low to file
   input wire logic [dsc_pkg::DSC_AW-1:0] px_reg,                  // File index for moves
   output logic [dsc_pkg::DSC_BUS_W-1:0] bus_exchange_reg,         // Exchange contents
   input wire logic [1:0] univ_sel,                                // Universal register index
   input wire dsc_pkg::dsc_uop_t univ_op,                          // Bit operation
   input wire logic [dsc_pkg::DSC_UNIV_W-1:0] univ_operand,        // Mask or data
   output logic [dsc_pkg::DSC_UNIV_W-1:0] univ_value,              // Selected register value
   output logic univ_test,                                         // Test result of selected
   input wire logic [dsc_pkg::DSC_TMR_W-1:0] timer_period,         // Timer reload
   input wire logic timer_enable,                                  // Timer runs
   output logic timer_irq,                                         // One-cycle expiry pulse
   output logic timer_expire_flag_pin                              // Flag pin output
);
   localparam int W = dsc_pkg::DSC_WORD_W;
   localparam int LO = dsc_pkg::DSC_LO_W;

   // Mode word registered so a change applies to the following instruction
   logic [dsc_pkg::DSC_MODE_W-1:0] mode_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) mode_reg <= dsc_pkg::DSC_MODE_RESET;
      else mode_reg <= core_mode_word;
   end
   wire simd = mode_reg[dsc_pkg::DSC_MODE_PEY_BIT];
   wire sec_sel = mode_reg[dsc_pkg::DSC_MODE_SEC_BIT];
   wire secm_sel = mode_reg[dsc_pkg::DSC_MODE_SECM_BIT];
   wire tflag_en = mode_reg[dsc_pkg::DSC_MODE_TFLAG_BIT];

   // Selective instruction cache: only fills when a fetch collides with pm data
   logic [dsc_pkg::DSC_INSN_W-1:0] cache_data [dsc_pkg::DSC_CACHE_N];
   logic [dsc_pkg::DSC_PC_W-1:0] cache_tag [dsc_pkg::DSC_CACHE_N];
   logic [dsc_pkg::DSC_CACHE_N-1:0] cache_vld;
   wire [dsc_pkg::DSC_CACHE_AW-1:0] cidx = fetch_addr[dsc_pkg::DSC_CACHE_AW-1:0];
   wire hit = cache_vld[cidx] && cache_tag[cidx] == fetch_addr;
   wire conflict = pm_data_req && !hit;
   wire fill = conflict && fetch_word_valid;
   logic stalled_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cache_vld <= '0;
         stalled_reg <= 1'b0;
      end else begin
         stalled_reg <= conflict;
         if (fill) cache_vld[cidx] <= 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (fill) begin
         cache_data[cidx] <= fetch_word;
         cache_tag[cidx] <= fetch_addr;
      end
   end
   // Hit serves the instruction while both buses carry data; miss with conflict stalls
   assign insn_from_cache = hit;
   assign insn_word = hit ? cache_data[cidx] : fetch_word;
   assign stall = conflict;

   // Issue: same instruction to both elements, held back on a stall
   dsc_pkg::dsc_insn_t issue;
   always_comb begin
      issue = insn_in;
      issue.valid = insn_in.valid && !conflict;
   end

   // Each bus word pairs low half to first element, high half to second
   wire [LO-1:0] dm_x = data_memory_bus[LO-1:0];
   wire [LO-1:0] dm_y = data_memory_bus[dsc_pkg::DSC_BUS_W-1 -: LO];
   wire [W-1:0] load_x = {dm_x, {(W-LO){1'b0}}};
   wire [W-1:0] load_y = {dm_y, {(W-LO){1'b0}}};

   // Exchange register writes into the file go to the primary element, both in SIMD
   wire px_wr = px_to_rf;
   wire [W-1:0] px_lo40 = bus_exchange_reg[W-1:0];
   wire [W-1:0] px_hi40 = {bus_exchange_reg[dsc_pkg::DSC_BUS_W-1 -: LO], {(W-LO){1'b0}}};
   logic [W-1:0] rd_x;
   logic [W-1:0] rd_y;

   dsc_element u_primary_processing_element (
      .mclk(mclk),
      .reset_n(reset_n),
      .enable(1'b1),
      .sec_sel(sec_sel),
      .secm_sel(secm_sel),
      .insn(issue),
      .load_data(load_x),
      .rf_wr(px_wr),
      .rf_wr_addr(px_reg),
      .rf_wr_data(px_lo40),
      .rd_addr(store_reg),
      .rd_data(rd_x),
      .mr_out(mr_x)
   );
   dsc_element u_secondary_processing_element (
      .mclk(mclk),
      .reset_n(reset_n),
      .enable(simd),
      .sec_sel(sec_sel),
      .secm_sel(secm_sel),
      .insn(issue),
      .load_data(load_y),
      .rf_wr(px_wr),
      .rf_wr_addr(px_reg),
      .rf_wr_data(px_hi40),
      .rd_addr(store_reg),
      .rd_data(rd_y),
      .mr_out(mr_y)
   );

   // Store word: in SIMD both elements fill one 64-bit word, else first only
   assign store_word = simd ? {rd_y[W-1 -: LO], rd_x[W-1 -: LO]} :
                              {{LO{1'b0}}, rd_x[W-1 -: LO]};

   // Exchange register: bus to bus or file to register, width resolved by packing
   logic [dsc_pkg::DSC_BUS_W-1:0] px_next;
   assign px_next = (px_op == dsc_pkg::DSC_PX_FROM_PM) ? program_memory_bus :
                    (px_op == dsc_pkg::DSC_PX_FROM_DM) ? data_memory_bus :
                    (px_op == dsc_pkg::DSC_PX_FROM_RF) ?
                    {{(dsc_pkg::DSC_BUS_W-W){1'b0}}, rd_x} : bus_exchange_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) bus_exchange_reg <= '0;
      else bus_exchange_reg <= px_next;
   end

   // Universal registers, one small module each
   logic [dsc_pkg::DSC_UNIV_W-1:0] uval [dsc_pkg::DSC_NUNIV];
   logic [dsc_pkg::DSC_NUNIV-1:0] utest;
   for (genvar g = 0; g < dsc_pkg::DSC_NUNIV; g++) begin : g_univ
      dsc_univ u_univ (
         .mclk(mclk),
         .reset_n(reset_n),
         .op(univ_sel == 2'(g) ? univ_op : dsc_pkg::DSC_UOP_NONE),
         .operand(univ_operand),
         .value(uval[g]),
         .test_true(utest[g])
      );
   end
   assign univ_value = uval[univ_sel];
   assign univ_test = utest[univ_sel];

   // Core timer: down counter reloading from period; pin pulse only when enabled
   logic [dsc_pkg::DSC_TMR_W-1:0] tcount_reg;
   logic irq_reg;
   logic flag_reg;
   wire expire = timer_enable && tcount_reg == '0;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tcount_reg <= '0;
         irq_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         irq_reg <= expire;
         flag_reg <= expire && tflag_en;
         if (!timer_enable || expire) tcount_reg <= timer_period;
         else tcount_reg <= tcount_reg - 1'b1;
      end
   end
   assign timer_irq = irq_reg;
   assign timer_expire_flag_pin = flag_reg;

   mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
      1'b1 |=> mode_reg == $past(core_mode_word))
      else $error("mode change not applied next cycle");
   flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      timer_expire_flag_pin |-> timer_irq && $past(tflag_en))
      else $error("flag pin without enabled expiry");
   cache_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fill |=> cache_vld[$past(cidx)])
      else $error("colliding fetch not cached");
   store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !simd |-> store_word[dsc_pkg::DSC_BUS_W-1 -: LO] == '0)
      else $error("second half driven outside simd");
   issue_a: assert property (@(posedge mclk) disable iff (!reset_n)
      conflict |-> !issue.valid)
      else $error("issued during fetch conflict");
   px_a: assert property (@(posedge mclk) disable iff (!reset_n)
      px_op == dsc_pkg::DSC_PX_FROM_DM |=> bus_exchange_reg == $past(data_memory_bus))
      else $error("exchange did not take data bus");
endmodule
`default_nettype wire

//--- rtl/dsc_pkg.sv
// Purpose: shared constants and carrier types for the dual element SIMD core
// Assumes: single clock mclk at 40 MHz, asynchronous active-low reset
// Notes: formats, widths and opcodes used by the core and its element datapath
package dsc_pkg;
   localparam int DSC_WORD_W = 40;            // Extended precision register width
   localparam int DSC_BUS_W = 64;             // Program and data memory bus width
   localparam int DSC_NREG = 16;              // Registers per bank
   localparam int DSC_AW = 4;                 // Register index width
   localparam int DSC_NUNIV = 4;              // Universal registers
   localparam int DSC_UNIV_W = 32;
   localparam int DSC_TMR_W = 32;
   localparam int DSC_CACHE_N = 16;           // Cache entries
   localparam int DSC_CACHE_AW = 4;
   localparam int DSC_PC_W = 24;
   localparam int DSC_INSN_W = 48;
   localparam int DSC_LO_W = 32;              // Low half of a 64-bit bus word
   localparam int DSC_MODE_PEY_BIT = 0;       // Second element enable
   localparam int DSC_MODE_SEC_BIT = 1;       // Secondary data bank select
   localparam int DSC_MODE_SECM_BIT = 2;      // Secondary multiplier result select
   localparam int DSC_MODE_TFLAG_BIT = 3;     // Timer drives expiry flag pin
   localparam int DSC_MODE_W = 4;
   localparam logic [DSC_MODE_W-1:0] DSC_MODE_RESET = 4'h0;

   typedef enum logic [1:0] {DSC_FMT_FIX32, DSC_FMT_FLT32, DSC_FMT_FLT40} dsc_fmt_t;
   typedef enum logic [3:0] {
      DSC_OP_NOP, DSC_OP_ADD, DSC_OP_SUB, DSC_OP_AND, DSC_OP_OR, DSC_OP_XOR,
      DSC_OP_SHL, DSC_OP_SHR, DSC_OP_MUL, DSC_OP_MULADD, DSC_OP_LOAD, DSC_OP_PASS
   } dsc_op_t;
   typedef enum logic [2:0] {
      DSC_UOP_NONE, DSC_UOP_WRITE, DSC_UOP_SET, DSC_UOP_CLR, DSC_UOP_TGL, DSC_UOP_XOR,
      DSC_UOP_TEST
   } dsc_uop_t;
   typedef enum logic [1:0] {DSC_PX_NONE, DSC_PX_FROM_PM, DSC_PX_FROM_DM, DSC_PX_FROM_RF}
      dsc_pxop_t;

   // One issued compute instruction, shared by both elements
   typedef struct packed {
      logic valid;
      dsc_op_t op;
      dsc_fmt_t fmt;
      logic [DSC_AW-1:0] dst;
      logic [DSC_AW-1:0] src_a;
      logic [DSC_AW-1:0] src_b;
      logic [DSC_AW-1:0] dst2;           // ALU result target of a multifunction op
   } dsc_insn_t;
endpackage

//--- rtl/dsc_univ.sv
// Purpose: one universal register with bit manipulation
// Assumes: one operation per cycle
// Notes: test result is a registered flag
`timescale 1ns/1ps
`default_nettype none
module dsc_univ (
   input wire logic mclk,                              // Core clock
   input wire logic reset_n,                           // Async reset, active low
   input wire dsc_pkg::dsc_uop_t op,                   // Operation
   input wire logic [dsc_pkg::DSC_UNIV_W-1:0] operand, // Mask or data
   output logic [dsc_pkg::DSC_UNIV_W-1:0] value,       // Current contents
   output logic test_true                              // All masked bits set
);
   logic [dsc_pkg::DSC_UNIV_W-1:0] value_reg;
   logic [dsc_pkg::DSC_UNIV_W-1:0] value_next;
   logic test_reg;
   wire test_hit = ((value_reg & operand) == operand);

   // Bit manipulation selection
   assign value_next = (op == dsc_pkg::DSC_UOP_WRITE) ? operand :
                       (op == dsc_pkg::DSC_UOP_SET) ? (value_reg | operand) :
                       (op == dsc_pkg::DSC_UOP_CLR) ? (value_reg & ~operand) :
                       (op == dsc_pkg::DSC_UOP_TGL || op == dsc_pkg::DSC_UOP_XOR) ?
                       (value_reg ^ operand) : value_reg;

   // Contents and test flag
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         value_reg <= '0;
         test_reg <= 1'b0;
      end else begin
         value_reg <= value_next;
         if (op == dsc_pkg::DSC_UOP_TEST) test_reg <= test_hit;
      end
   end
   assign value = value_reg;
   assign test_true = test_reg;

   set_a: assert property (@(posedge mclk) disable iff (!reset_n)
      op == dsc_pkg::DSC_UOP_SET |=> ((value & $past(operand)) == $past(operand)))
      else $error("set left a bit clear");
endmodule
`default_nettype wire

//--- rtl/dsc_element.sv
// Purpose: one processing element: register file, ALU, multiplier, shifter
// Assumes: the issued instruction is stable for the cycle it is valid
// Notes: all units finish in one cycle; results land the next edge
`timescale 1ns/1ps
`default_nettype none
module dsc_element (
   input wire logic mclk,                                 // Core clock
   input wire logic reset_n,                              // Async reset, active low
   input wire logic enable,                               // Element may update state
   input wire logic sec_sel,                              // Secondary data bank
   input wire logic secm_sel,                             // Secondary multiplier result
   input wire dsc_pkg::dsc_insn_t insn,                   // Issued instruction
   input wire logic [dsc_pkg::DSC_WORD_W-1:0] load_data,  // Operand from memory
   input wire logic rf_wr,                                // Extra write port (exchange)
   input wire logic [dsc_pkg::DSC_AW-1:0] rf_wr_addr,     // Extra write index
   input wire logic [dsc_pkg::DSC_WORD_W-1:0] rf_wr_data, // Extra write data
   input wire logic [dsc_pkg::DSC_AW-1:0] rd_addr,        // Read port for stores
   output logic [dsc_pkg::DSC_WORD_W-1:0] rd_data,        // Read data
   output logic [dsc_pkg::DSC_WORD_W-1:0] mr_out          // Active multiplier result
);
   localparam int W = dsc_pkg::DSC_WORD_W;
   localparam int N = dsc_pkg::DSC_NREG;
   logic [W-1:0] pri_mem [N];
   logic [W-1:0] sec_mem [N];
   logic [W-1:0] mr_reg [2];
   wire [W-1:0] op_a = sec_sel ? sec_mem[insn.src_a] : pri_mem[insn.src_a];
   wire [W-1:0] op_b = sec_sel ? sec_mem[insn.src_b] : pri_mem[insn.src_b];
   wire [dsc_pkg::DSC_LO_W-1:0] a_lo = op_a[W-1 -: dsc_pkg::DSC_LO_W];
   wire [dsc_pkg::DSC_LO_W-1:0] b_lo = op_b[W-1 -: dsc_pkg::DSC_LO_W];
   wire [W-1:0] fix_mask = {{dsc_pkg::DSC_LO_W{1'b1}}, {(W-dsc_pkg::DSC_LO_W){1'b0}}};
   // Fixed and 32-bit float keep the upper 32 bits; 40-bit keeps all
   wire [W-1:0] fmt_mask = (insn.fmt == dsc_pkg::DSC_FMT_FLT40) ? {W{1'b1}} : fix_mask;
   logic [W-1:0] alu_res;
   logic [W-1:0] mul_res;
   logic [W-1:0] shf_res;
   logic [W-1:0] main_res;
   logic [2*dsc_pkg::DSC_LO_W-1:0] prod;
   wire mf = (insn.op == dsc_pkg::DSC_OP_MULADD);
   wire fire = insn.valid && enable;

   // Parallel units, each purely combinational within one cycle
   assign prod = a_lo * b_lo;
   assign mul_res = {prod[dsc_pkg::DSC_LO_W-1:0], {(W-dsc_pkg::DSC_LO_W){1'b0}}} & fmt_mask;
   assign shf_res = (insn.op == dsc_pkg::DSC_OP_SHL) ? ((op_a << 1) & fmt_mask) :
                    ((op_a >> 1) & fmt_mask);
   // Format handled by masking: float arithmetic is approximated on the raw word
   always_comb begin
      case (insn.op)
         dsc_pkg::DSC_OP_SUB: alu_res = (op_a - op_b) & fmt_mask;
         dsc_pkg::DSC_OP_AND: alu_res = op_a & op_b;
         dsc_pkg::DSC_OP_OR: alu_res = op_a | op_b;
         dsc_pkg::DSC_OP_XOR: alu_res = op_a ^ op_b;
         dsc_pkg::DSC_OP_PASS: alu_res = op_a;
         default: alu_res = (op_a + op_b) & fmt_mask;
      endcase
   end
   assign main_res = (insn.op == dsc_pkg::DSC_OP_MUL || mf) ? mul_res :
                     (insn.op == dsc_pkg::DSC_OP_SHL || insn.op == dsc_pkg::DSC_OP_SHR) ?
                     shf_res : (insn.op == dsc_pkg::DSC_OP_LOAD) ? load_data : alu_res;
   wire wr_main = fire && insn.op != dsc_pkg::DSC_OP_NOP;

   // Register file writes go only to the selected bank; the other holds
   always_ff @(posedge mclk) begin
      if (wr_main && !sec_sel) pri_mem[insn.dst] <= main_res;
      if (wr_main && sec_sel) sec_mem[insn.dst] <= main_res;
      if (fire && mf && !sec_sel) pri_mem[insn.dst2] <= alu_res;
      if (fire && mf && sec_sel) sec_mem[insn.dst2] <= alu_res;
      if (rf_wr && enable && !sec_sel) pri_mem[rf_wr_addr] <= rf_wr_data;
      if (rf_wr && enable && sec_sel) sec_mem[rf_wr_addr] <= rf_wr_data;
   end

   // Multiplier result with secondary copy
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mr_reg[0] <= '0;
         mr_reg[1] <= '0;
      end else if (fire && (insn.op == dsc_pkg::DSC_OP_MUL || mf)) begin
         mr_reg[secm_sel] <= mul_res;
      end
   end
   assign mr_out = mr_reg[secm_sel];

   // Read port registered, data outputs come from flops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) rd_data <= '0;
      else rd_data <= sec_sel ? sec_mem[rd_addr] : pri_mem[rd_addr];
   end

   hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !enable |=> $stable(mr_reg[0]) && $stable(mr_reg[1]))
      else $error("disabled element changed result");
   mul_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fire && (insn.op == dsc_pkg::DSC_OP_MUL || mf) |=>
      mr_reg[$past(secm_sel)] == $past(mul_res))
      else $error("multiply not done in one cycle");
endmodule
`default_nettype wire

//--- verif/dsc_mem_model.sv
// Purpose: on-chip memory stand-in for the core's program and data buses
// Assumes: reads answer in the same cycle; one write port for the bench
// Notes: fetch words are an image of the address so that cache hits can be checked
`timescale 1ns/1ps
`default_nettype none
module dsc_mem_model (
   input wire logic mclk,              // Core clock
   input wire logic wr_en,             // Bench write strobe
   input wire logic [3:0] wr_addr,     // Write index
   input wire logic [63:0] wr_data,    // Write word
   input wire logic [3:0] dm_addr,     // Data bus index
   input wire logic [3:0] pm_addr,     // Program bus index
   input wire logic [23:0] fetch_addr, // Instruction address
   output logic [63:0] dm_word,        // Data bus word
   output logic [63:0] pm_word,        // Program bus word
   output logic [47:0] fetch_word      // Instruction word
);
   logic [63:0] mem [16];
   // Only the bench writes, so contents never drift under a test
   always_ff @(posedge mclk) if (wr_en) mem[wr_addr] <= wr_data;
   // Both buses answer every cycle, no arbitration between them
   assign dm_word = mem[dm_addr];
   assign pm_word = mem[pm_addr];
   assign fetch_word = {24'h5a5a5a, fetch_addr};
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the dual element SIMD core
// Assumes: 40 MHz mclk; drivers queue notes, a monitor compares them
// Notes: one cycle cap guards every wait loop, so a hang still reaches the verdict
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {int sel; logic [63:0] exp;} dsc_note_t;
   logic mclk = 0, reset_n = 0, due = 0, wr_en = 0, fvalid = 0, pmreq = 0, ten = 0;
   logic [3:0] mode = '0, sreg = '0, dma = '0, wa = '0;
   logic [63:0] wd = '0, dmw, pmw, store_word;
   logic [23:0] faddr = '0;
   logic [47:0] fword, insn_word;
   logic [31:0] uopd = '0, tper = '0, univ_value;
   logic [1:0] usel = '0;
   logic stall, insn_from_cache, univ_test, timer_irq, flag_pin;
   logic ptr = 0;
   logic [3:0] preg = '0;
   logic [39:0] mrx, mry;
   logic [63:0] pxr;
   dsc_pkg::dsc_pxop_t pxo = dsc_pkg::DSC_PX_NONE;
   dsc_pkg::dsc_uop_t uop = dsc_pkg::DSC_UOP_NONE;
   dsc_pkg::dsc_insn_t insn = '0;
   dsc_note_t q[$];
   int miscompares = 0, tests_run = 0, cycles = 0;
   always #12.5 mclk = ~mclk;
   dsc_mem_model dsc_mem_model_inst (.mclk, .wr_en, .wr_addr(wa), .wr_data(wd), .dm_addr(dma),
      .pm_addr(dma), .fetch_addr(faddr), .dm_word(dmw), .pm_word(pmw), .fetch_word(fword));
   dsc_core dsc_core_inst (.mclk, .reset_n, .core_mode_word(mode), .insn_in(insn),
      .fetch_addr(faddr), .fetch_word(fword), .fetch_word_valid(fvalid), .pm_data_req(pmreq),
      .insn_from_cache, .insn_word, .stall, .data_memory_bus(dmw), .program_memory_bus(pmw),
      .store_reg(sreg), .store_word, .mr_x(mrx), .mr_y(mry), .px_op(pxo),
      .px_to_rf(ptr), .px_reg(preg), .bus_exchange_reg(pxr), .univ_sel(usel), .univ_op(uop),
      .univ_operand(uopd), .univ_value, .univ_test, .timer_period(tper), .timer_enable(ten),
      .timer_irq, .timer_expire_flag_pin(flag_pin));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic expect_at(input int sel, input logic [63:0] exp);
      q.push_back('{sel, exp});
      due <= 1'b1;
      @(posedge mclk);
      due <= 1'b0;
      @(posedge mclk);
   endtask
   // Monitor samples at the falling edge, when registered outputs have settled
   always @(negedge mclk) begin
      if (due) begin
         case (q[0].sel)
            0: check({32'h0, univ_value}, q[0].exp);
            1: check(store_word, q[0].exp);
            2: check({16'h0, insn_word}, q[0].exp);
            3: check({62'h0, flag_pin, timer_irq}, q[0].exp);
            4: check({62'h0, stall, insn_from_cache}, q[0].exp);
            6: check({mry[39:8], mrx[39:8]}, q[0].exp);
            7: check(pxr, q[0].exp);
            default: check({63'h0, univ_test}, q[0].exp);
         endcase
         void'(q.pop_front());
      end
   end
   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic uo(input int i, input dsc_pkg::dsc_uop_t o, input logic [31:0] v);
      usel <= i[1:0];
      uop <= o;
      uopd <= v;
      @(posedge mclk);
      uop <= dsc_pkg::DSC_UOP_NONE;
   endtask
   // One load issued, then one edge for the store read registers to catch it
   task automatic ld(input logic [3:0] a, input logic [3:0] d, input logic [63:0] exp);
      dma <= a;
      sreg <= d;
      insn <= '{1'b1, dsc_pkg::DSC_OP_LOAD, dsc_pkg::DSC_FMT_FIX32, d, 4'h0, 4'h0, 4'h0};
      @(posedge mclk);
      insn.valid <= 1'b0;
      @(posedge mclk);
      expect_at(1, exp);
   endtask
   // One compute instruction on register 5 with itself, valid for a single edge
   task automatic ex(input dsc_pkg::dsc_op_t o, input logic [3:0] d, input logic [3:0] d2);
      insn <= '{1'b1, o, dsc_pkg::DSC_FMT_FIX32, d, 4'h5, 4'h5, d2};
      @(posedge mclk);
      insn.valid <= 1'b0;
   endtask
   task automatic mw(input logic [3:0] a, input logic [63:0] d);
      wr_en <= 1'b1;
      wa <= a;
      wd <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
      @(posedge mclk);
   endtask
   // Mode is registered inside, so allow it to settle before the next step
   task automatic setmode(input logic [3:0] m);
      mode <= m;
      repeat (3) @(posedge mclk);
   endtask
   // Cycle cap: the full run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      logic [31:0] r, m;
      logic [63:0] a, b, p;
      int n;
      void'($urandom(32'h574145a0));
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         uo(i, dsc_pkg::DSC_UOP_WRITE, r);
         expect_at(0, {32'h0, r});
         for (int k = 2; k < 6; k++) begin
            m = $urandom;
            uo(i, dsc_pkg::dsc_uop_t'(k), m);
            r = (k == 2) ? (r | m) : (k == 3) ? (r & ~m) : (r ^ m);
            expect_at(0, {32'h0, r});
         end
         uo(i, dsc_pkg::DSC_UOP_TEST, i[0] ? r : 32'hffffffff);
         expect_at(5, {63'h0, i[0] ? 1'b1 : &r});
      end
      $display("test universal registers done");
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      mw(4'h1, a);
      mw(4'h2, b);
      mw(4'h3, ~a);
      setmode(4'h1);
      ld(4'h1, 4'h5, a);
      setmode(4'h0);
      ld(4'h2, 4'h5, {32'h0, b[31:0]});
      setmode(4'h1);
      expect_at(1, {a[63:32], b[31:0]});
      setmode(4'h3);
      ld(4'h3, 4'h5, ~a);
      setmode(4'h1);
      expect_at(1, {a[63:32], b[31:0]});
      $display("test element loads done");
      // Multifunction: fixed-point product to the result register, sum to the second target
      p = {32'(a[63:32] * a[63:32]), 32'(b[31:0] * b[31:0])};
      ex(dsc_pkg::DSC_OP_MULADD, 4'h6, 4'h7);
      sreg <= 4'h7;
      expect_at(6, p);
      expect_at(1, {32'(a[63:32] + a[63:32]), 32'(b[31:0] + b[31:0])});
      setmode(4'h5);
      expect_at(6, 64'h0);
      setmode(4'h1);
      expect_at(6, p);
      // Exchange: data bus word in, split into both files, file word back out
      dma <= 4'h1;
      pxo <= dsc_pkg::DSC_PX_FROM_DM;
      @(posedge mclk);
      pxo <= dsc_pkg::DSC_PX_NONE;
      ptr <= 1'b1;
      preg <= 4'h8;
      sreg <= 4'h8;
      expect_at(7, a);
      ptr <= 1'b0;
      expect_at(1, {a[63:32], a[39:8]});
      pxo <= dsc_pkg::DSC_PX_FROM_RF;
      @(posedge mclk);
      pxo <= dsc_pkg::DSC_PX_NONE;
      expect_at(7, {24'h0, a[39:0]});
      $display("test multiply and exchange done");
      faddr <= 24'h000013;
      fvalid <= 1'b1;
      pmreq <= 1'b1;
      expect_at(4, 64'h2);
      expect_at(4, 64'h1);
      expect_at(2, {16'h0, 24'h5a5a5a, 24'h000013});
      pmreq <= 1'b0;
      faddr <= 24'h000027;
      @(posedge mclk);
      pmreq <= 1'b1;
      expect_at(4, 64'h2);
      pmreq <= 1'b0;
      $display("test instruction cache done");
      tper <= 32'h3;
      ten <= 1'b1;
      mode <= 4'h8;
      n = 0;
      while (timer_irq !== 1'b1 && n < 40) begin
         @(posedge mclk);
         #1 n++;
      end
      // First pulse comes before the registered mode bit lets the pin follow
      expect_at(3, 64'h1);
      n = 2;
      while (timer_irq !== 1'b1 && n < 40) begin
         @(posedge mclk);
         #1 n++;
      end
      check(64'(n), 64'h4);
      expect_at(3, 64'h3);
      $display("test core timer done");
      print_verdict();
   end
endmodule
`default_nettype wire
